// *** design/sci_meas_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface sci_meas_if;
    logic pin_level;
    logic pin_rise;
    logic [23:0] high_cnt;
    logic [23:0] period_cnt;
    logic period_done;
    logic [23:0] edge_cnt;
    logic gate_done;
    modport meas (
        input pin_level,
        input pin_rise,
        output high_cnt,
        output period_cnt,
        output period_done,
        output edge_cnt,
        output gate_done
    );
    modport ctrl (
        output pin_level,
        output pin_rise,
        input high_cnt,
        input period_cnt,
        input period_done,
        input edge_cnt,
        input gate_done
    );
endinterface
`default_nettype wire

// *** design/sci_pkg.sv ***
package sci_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int unsigned SCI_DUTY_W = 16;
    localparam int unsigned SCI_ADC_W = 12;
    localparam int unsigned SCI_CNT_W = 24;
    localparam int unsigned SCI_SEL_W = 2;

    // ----------------------------------------
    // Speed input select encodings
    // ----------------------------------------
    localparam logic [1:0] SCI_SEL_ANALOG = 2'h0;
    localparam logic [1:0] SCI_SEL_PWM = 2'h1;
    localparam logic [1:0] SCI_SEL_I2C = 2'h2;
    localparam logic [1:0] SCI_SEL_FREQ = 2'h3;

    // ----------------------------------------
    // Device power mode encodings
    // ----------------------------------------
    localparam logic SCI_PMODE_STANDBY = 1'h0;
    localparam logic SCI_PMODE_SLEEP = 1'h1;

    // ----------------------------------------
    // Values and reset values
    // ----------------------------------------
    localparam logic [15:0] SCI_DUTY_FULL = 16'hFFFF;
    localparam logic [15:0] SCI_DUTY_ZERO = 16'h0000;
    localparam logic [23:0] SCI_CNT_ZERO = 24'h000000;
    localparam logic [23:0] SCI_CNT_SAT = 24'hFFFFFF;
    localparam logic [1:0] SCI_PIN_SYNC_RST = 2'h0;

    // ----------------------------------------
    // Frequency window: gate time at range 0, doubled per range step
    // ----------------------------------------
    localparam real SCI_CLK_MHZ = 200.0;
    localparam real SCI_FREQ_GATE_US = 1000.0;
    localparam int unsigned SCI_FREQ_GATE_CYC = int'(SCI_FREQ_GATE_US * SCI_CLK_MHZ);

    typedef enum logic [1:0] {
        SCI_MEAS_IDLE = 2'b00,
        SCI_MEAS_HIGH = 2'b01,
        SCI_MEAS_LOW = 2'b11
    } sci_meas_t;
endpackage

// *** design/sci_pulse_meas.sv ***
`timescale 1ns/10ps
`default_nettype none
module sci_pulse_meas #(
    parameter int unsigned GATE_CYC = sci_pkg::SCI_FREQ_GATE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] freq_range_sel,
    sci_meas_if.meas m
);
    import sci_pkg::*;

    typedef struct packed {
        sci_meas_t st;
        logic [23:0] hi;
        logic [23:0] per;
        logic [23:0] hi_out;
        logic [23:0] per_out;
        logic done;
        logic [31:0] gate;
        logic [23:0] edges;
        logic [23:0] edges_out;
        logic gdone;
    } sci_pm_t;

    sci_pm_t s_ff;
    sci_pm_t nxt_s;
    logic [31:0] gate_len;

    // Longer gate for lower frequency ranges
    assign gate_len = 32'(GATE_CYC) << freq_range_sel;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.gdone = 1'b0;
        if (s_ff.per != SCI_CNT_SAT) begin
            nxt_s.per = s_ff.per + 24'h000001;
        end
        if (m.pin_level && s_ff.hi != SCI_CNT_SAT) begin
            nxt_s.hi = s_ff.hi + 24'h000001;
        end
        unique case (s_ff.st)
            SCI_MEAS_IDLE: begin
                if (m.pin_rise) begin
                    nxt_s.st = SCI_MEAS_HIGH;
                    nxt_s.hi = SCI_CNT_ZERO;
                    // Rise cycle is the first of the new period
                    nxt_s.per = 24'h000001;
                end
            end
            SCI_MEAS_HIGH, SCI_MEAS_LOW: begin
                if (!m.pin_level) begin
                    nxt_s.st = SCI_MEAS_LOW;
                end
                if (m.pin_rise) begin
                    // One result per input period
                    nxt_s.hi_out = s_ff.hi; // R16
                    nxt_s.per_out = s_ff.per; // R16
                    nxt_s.done = 1'b1;
                    nxt_s.hi = SCI_CNT_ZERO;
                    nxt_s.per = 24'h000001; // R16
                    nxt_s.st = SCI_MEAS_HIGH;
                end else if (s_ff.per == SCI_CNT_SAT) begin
                    // Pin stuck: report static level
                    nxt_s.hi_out = m.pin_level ? SCI_CNT_SAT : SCI_CNT_ZERO;
                    nxt_s.per_out = SCI_CNT_SAT;
                    nxt_s.done = 1'b1;
                    nxt_s.st = SCI_MEAS_IDLE;
                end
            end
            default: begin
                nxt_s.st = SCI_MEAS_IDLE;
            end
        endcase
        // Edge counting over a gate window
        if (m.pin_rise && s_ff.edges != SCI_CNT_SAT) begin
            nxt_s.edges = s_ff.edges + 24'h000001;
        end
        if (s_ff.gate + 32'h1 >= gate_len) begin
            nxt_s.gate = 32'h0;
            nxt_s.edges_out = s_ff.edges; // R6
            // Edge in the closing cycle opens the next window
            nxt_s.edges = m.pin_rise ? 24'h000001 : SCI_CNT_ZERO; // R6
            nxt_s.gdone = 1'b1;
        end else begin
            nxt_s.gate = s_ff.gate + 32'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign m.high_cnt = s_ff.hi_out;
    assign m.period_cnt = s_ff.per_out;
    assign m.period_done = s_ff.done;
    assign m.edge_cnt = s_ff.edges_out;
    assign m.gate_done = s_ff.gdone;
endmodule
`default_nettype wire

// *** design/sci_speed_cmd.sv ***
// Summary of operation
// [R1] Four speed sources exist (pin duty, pin frequency, pin level, written word), chosen by speed_sel.
// [R2] With speed_sel 00b the duty command follows the converted pin level.
// [R3] Analog: at or below entry code zero, linear from exit code to full scale, clamped above it.
// [R4] With speed_sel 01b the duty command follows the pin pulse duty over 0 to 100%.
// [R5] PWM: at or below entry duty zero, linear from exit duty to full duty.
// [R6] Pin frequency is measured over a window chosen by freq_range_sel.
// [R7] Pin frequency measurement is independent of the drive switching rate setting.
// [R8] Analog, PWM and frequency modes work only when device_power_mode is 0b.
// [R9] The written word mode works for both values of device_power_mode.
// [R10] A top speed limit of zero holds the speed target at zero.
// [R11] The host waits 200 ms after power-up or wake before giving a speed command.
// [R12] The host sets the sleep entry delay longer than the input low time at lowest duty.
// [R13] With speed_sel 10b the command is taken from the written speed word.
// [R14] With speed_sel 11b the command follows the pin frequency linearly.
// [R15] A zero command stops the motor in every mode.
// [R16] PWM duty is measured by counting clocks of high time and period, updated once per period.
// [R17] Analog level arrives as a conversion code compared with threshold codes.
`timescale 1ns/10ps
`default_nettype none
module sci_speed_cmd #(
    parameter int unsigned GATE_CYC = sci_pkg::SCI_FREQ_GATE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] speed_sel,
    input wire logic device_power_mode,
    input wire logic [1:0] freq_range_sel,
    input wire logic speed_pin,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] adc_code,
    input wire logic adc_valid,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] standby_entry_voltage,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] standby_exit_voltage,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] analog_full_scale,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] standby_entry_duty,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] standby_exit_duty,
    input wire logic [sci_pkg::SCI_CNT_W-1:0] standby_entry_freq,
    input wire logic [sci_pkg::SCI_CNT_W-1:0] standby_exit_freq,
    input wire logic [sci_pkg::SCI_CNT_W-1:0] input_max_freq,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] speed_word,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] max_speed,
    output logic [sci_pkg::SCI_DUTY_W-1:0] duty_cmd,
    output logic [sci_pkg::SCI_DUTY_W-1:0] speed_target,
    output logic motor_stop,
    output logic mode_allowed
);
    import sci_pkg::*;

    typedef struct packed {
        logic [2:0] sync;
        logic pin_q;
        logic [15:0] duty;
        logic [15:0] tgt;
        logic stop;
        logic allowed;
        logic [15:0] ana_duty;
        logic [15:0] pwm_duty;
        logic [15:0] frq_duty;
    } sci_top_t;

    sci_top_t s_ff;
    sci_top_t nxt_s;
    sci_meas_if mif ();

    // ----------------------------------------
    // Pin measurement
    // ----------------------------------------
    assign mif.pin_level = s_ff.pin_q;
    assign mif.pin_rise = (s_ff.sync[2] == s_ff.sync[1]) && s_ff.sync[2] && !s_ff.pin_q;

    // Counts core clocks only; drive PWM rate plays no part
    sci_pulse_meas #(.GATE_CYC(GATE_CYC)) u_meas ( // R7
        .clk(clk),
        .reset(reset),
        .freq_range_sel(freq_range_sel),
        .m(mif.meas)
    );

    // ----------------------------------------
    // Linear mapping helper
    // ----------------------------------------
    function automatic logic [15:0] lin_map(
        input logic [23:0] x,
        input logic [23:0] ent,
        input logic [23:0] ex,
        input logic [23:0] fs
    );
        logic [47:0] num;
        logic [23:0] span;
        logic [47:0] q;
        num = '0;
        span = '0;
        q = '0;
        if (x <= ent) begin
            lin_map = SCI_DUTY_ZERO;
        end else if (x >= fs) begin
            lin_map = SCI_DUTY_FULL;
        end else if (x < ex) begin
            // Hysteresis band between entry and exit: start at bottom of ramp
            lin_map = SCI_DUTY_ZERO;
        end else begin
            span = (fs > ex) ? (fs - ex) : 24'h000001;
            num = {24'h000000, x - ex} * 48'h00000000FFFF;
            q = num / {24'h000000, span};
            lin_map = q[15:0];
        end
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic [23:0] pwm_ratio;
    logic [47:0] pwm_num;
    logic [47:0] pwm_q;
    logic [15:0] sel_duty;
    logic [15:0] cap;

    always_comb begin
        pwm_num = {24'h000000, mif.high_cnt} * 48'h00000000FFFF;
        pwm_q = (mif.period_cnt == SCI_CNT_ZERO) ? 48'h0 : pwm_num / {24'h000000, mif.period_cnt};
        pwm_ratio = {8'h00, pwm_q[15:0]}; // R16
        nxt_s = s_ff;
        nxt_s.sync = {s_ff.sync[1:0], speed_pin};
        if (s_ff.sync[2] == s_ff.sync[1]) begin
            nxt_s.pin_q = s_ff.sync[2];
        end
        if (adc_valid) begin
            nxt_s.ana_duty = lin_map({12'h000, adc_code}, {12'h000, standby_entry_voltage},
                {12'h000, standby_exit_voltage}, {12'h000, analog_full_scale}); // R2 R3 R17
        end
        if (mif.period_done) begin
            nxt_s.pwm_duty = lin_map(pwm_ratio, {8'h00, standby_entry_duty},
                {8'h00, standby_exit_duty}, 24'h00FFFF); // R4 R5
        end
        if (mif.gate_done) begin
            nxt_s.frq_duty = lin_map(mif.edge_cnt, standby_entry_freq, standby_exit_freq,
                input_max_freq); // R14 R6
        end
        nxt_s.allowed = (speed_sel == SCI_SEL_I2C) || (device_power_mode == SCI_PMODE_STANDBY); // R8 R9
        sel_duty = SCI_DUTY_ZERO;
        unique case (speed_sel) // R1
            SCI_SEL_ANALOG: sel_duty = s_ff.ana_duty;
            SCI_SEL_PWM: sel_duty = s_ff.pwm_duty;
            SCI_SEL_I2C: sel_duty = speed_word; // R13
            SCI_SEL_FREQ: sel_duty = s_ff.frq_duty;
        endcase
        nxt_s.duty = nxt_s.allowed ? sel_duty : SCI_DUTY_ZERO; // R8
        cap = (nxt_s.duty > max_speed) ? max_speed : nxt_s.duty;
        nxt_s.tgt = (max_speed == SCI_DUTY_ZERO) ? SCI_DUTY_ZERO : cap; // R10
        nxt_s.stop = (nxt_s.duty == SCI_DUTY_ZERO) || (max_speed == SCI_DUTY_ZERO); // R15 R10
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_ff <= '0;
            s_ff.stop <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign duty_cmd = s_ff.duty;
    assign speed_target = s_ff.tgt;
    assign motor_stop = s_ff.stop;
    assign mode_allowed = s_ff.allowed;
endmodule
`default_nettype wire

// *** test/sci_pin_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module sci_pin_host (
    input wire logic clk,
    input wire logic en,
    input wire logic [15:0] period,
    input wire logic [15:0] high_t,
    output var logic speed_pin
);
    logic [15:0] cnt = 16'h0000;
    // ----------------------------------------
    // Pulse train, moved on the falling edge
    // ----------------------------------------
    always @(negedge clk) begin
        if (!en) begin
            cnt <= 16'h0000;
            speed_pin <= 1'b0;
        end else begin
            cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
            speed_pin <= (cnt < high_t);
        end
    end
endmodule
`default_nettype wire

// *** test/sci_speed_cmd_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module sci_speed_cmd_sva #(
    parameter int unsigned GATE_CYC = sci_pkg::SCI_FREQ_GATE_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] speed_sel,
    input wire logic device_power_mode,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] adc_code,
    input wire logic adc_valid,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] standby_entry_voltage,
    input wire logic [sci_pkg::SCI_ADC_W-1:0] analog_full_scale,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] speed_word,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] max_speed,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] duty_cmd,
    input wire logic [sci_pkg::SCI_DUTY_W-1:0] speed_target,
    input wire logic motor_stop,
    input wire logic mode_allowed
);
    import sci_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    AST_ALLOWED: assert property (!$past(reset) |->
        mode_allowed == ($past(speed_sel) == SCI_SEL_I2C || !$past(device_power_mode)))
        else $error("mode_allowed wrong");
    AST_REFUSED: assert property (!$past(reset) && $past(device_power_mode) &&
        $past(speed_sel) != SCI_SEL_I2C |-> duty_cmd == SCI_DUTY_ZERO)
        else $error("pin mode not refused");
    AST_WORD: assert property (!$past(reset) && $past(speed_sel) == SCI_SEL_I2C |->
        duty_cmd == $past(speed_word)) else $error("duty does not follow word");
    AST_STOP: assert property (motor_stop == (speed_target == SCI_DUTY_ZERO))
        else $error("motor_stop wrong");
    AST_LIMIT: assert property (!$past(reset) && $stable(max_speed) |->
        speed_target == ((duty_cmd < max_speed) ? duty_cmd : max_speed))
        else $error("speed_target not limited");
    AST_ZERO_LIMIT: assert property ((max_speed == SCI_DUTY_ZERO) [*2] |->
        motor_stop && speed_target == SCI_DUTY_ZERO) else $error("zero limit ignored");
    AST_AN_LOW: assert property (adc_valid && speed_sel == SCI_SEL_ANALOG &&
        !device_power_mode && adc_code <= standby_entry_voltage |-> ##2
        duty_cmd == SCI_DUTY_ZERO) else $error("analog low not zero");
    AST_AN_CLAMP: assert property (adc_valid && speed_sel == SCI_SEL_ANALOG &&
        !device_power_mode && adc_code > analog_full_scale |=> ##1
        duty_cmd == SCI_DUTY_FULL) else $error("analog not clamped");
    cover property (adc_valid && adc_code > analog_full_scale);
    cover property (speed_sel == SCI_SEL_I2C && device_power_mode && !motor_stop);
    cover property (max_speed == SCI_DUTY_ZERO && duty_cmd != SCI_DUTY_ZERO);
endmodule
bind sci_speed_cmd sci_speed_cmd_sva #(.GATE_CYC(GATE_CYC)) u_sva (
    .clk(clk), .reset(reset), .speed_sel(speed_sel), .device_power_mode(device_power_mode),
    .adc_code(adc_code), .adc_valid(adc_valid), .standby_entry_voltage(standby_entry_voltage),
    .analog_full_scale(analog_full_scale), .speed_word(speed_word), .max_speed(max_speed),
    .duty_cmd(duty_cmd), .speed_target(speed_target), .motor_stop(motor_stop),
    .mode_allowed(mode_allowed)
);
`default_nettype wire

// *** test/sci_speed_cmd_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sci_speed_cmd_tb;
    import sci_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] sel = SCI_SEL_I2C;
    logic [1:0] range = 2'h0;
    logic pmode = SCI_PMODE_STANDBY;
    logic adc_valid = 1'b0;
    logic host_en = 1'b0;
    logic speed_pin;
    logic motor_stop;
    logic mode_allowed;
    logic [11:0] adc_code = 12'h000;
    logic [11:0] ent_v = 12'h100;
    logic [11:0] fs_v = 12'hE00;
    logic [11:0] ex_v = 12'h200;
    logic [15:0] ex_d = 16'h2000;
    logic [15:0] word = 16'h0000;
    logic [15:0] max_speed = 16'hFFFF;
    logic [15:0] period = 16'h0064;
    logic [15:0] high_t = 16'h0032;
    logic [15:0] duty_cmd;
    logic [15:0] speed_target;
    logic [15:0] wl [4] = '{16'h0001, 16'h8000, 16'hFFFF, 16'h0000};
    int errors = 0;
    int n_checks = 0;
    sci_speed_cmd #(.GATE_CYC(100)) uut (.clk(clk), .reset(reset), .speed_sel(sel),
        .device_power_mode(pmode), .freq_range_sel(range), .speed_pin(speed_pin),
        .adc_code(adc_code), .adc_valid(adc_valid), .standby_entry_voltage(ent_v),
        .standby_exit_voltage(ex_v), .analog_full_scale(fs_v),
        .standby_entry_duty(16'h1000), .standby_exit_duty(ex_d),
        .standby_entry_freq(24'h000001), .standby_exit_freq(24'h000002),
        .input_max_freq(24'h000005), .speed_word(word), .max_speed(max_speed),
        .duty_cmd(duty_cmd), .speed_target(speed_target), .motor_stop(motor_stop),
        .mode_allowed(mode_allowed));
    sci_pin_host host (.clk(clk), .en(host_en), .period(period), .high_t(high_t),
        .speed_pin(speed_pin));
    initial forever #2.5 clk = ~clk;
    initial begin
        #200000;
        errors++;
        summarize();
    end
    // ----------------------------------------
    // Checks and stimulus
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g, input int t);
        n_checks++;
        if ($isunknown(g) || ((g > e) ? g - e : e - g) > t) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [15:0] lin(input longint x, input longint ex, input longint fs);
        return 16'((x - ex) * 65535 / (fs - ex));
    endfunction
    task automatic adc(input logic [11:0] c, input logic [15:0] e, input int t);
        adc_code = c;
        adc_valid = 1'b1;
        @(negedge clk);
        adc_valid = 1'b0;
        repeat (2) @(negedge clk);
        chk("adc_duty", e, duty_cmd, t);
    endtask
    task automatic pin(input logic [1:0] r, input logic [15:0] p, input logic [15:0] h,
        input logic [15:0] e, input int t);
        range = r;
        period = p;
        high_t = h;
        repeat (1000) @(negedge clk);
        chk("pin_duty", e, duty_cmd, t);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        chk("rst_stop", 16'h0001, {15'h0, motor_stop}, 0);
        reset = 1'b0;
        repeat (40) @(negedge clk);
        pmode = SCI_PMODE_SLEEP;
        foreach (wl[i]) begin
            word = wl[i];
            @(negedge clk);
            chk("word_duty", wl[i], duty_cmd, 0);
            chk("word_stop", {15'h0, wl[i] == 16'h0000}, {15'h0, motor_stop}, 0);
        end
        chk("allowed", 16'h0001, {15'h0, mode_allowed}, 0);
        word = 16'h8000;
        max_speed = 16'h0000;
        repeat (2) @(negedge clk);
        chk("lim_zero", 16'h0000, speed_target, 0);
        max_speed = 16'h0100;
        repeat (2) @(negedge clk);
        chk("lim_cap", 16'h0100, speed_target, 0);
        max_speed = 16'hFFFF;
        $display("word test done");
        sel = SCI_SEL_ANALOG;
        adc(12'hE01, 16'h0000, 0);
        chk("refused_allowed", 16'h0000, {15'h0, mode_allowed}, 0);
        pmode = SCI_PMODE_STANDBY;
        adc(12'h100, 16'h0000, 0);
        adc(12'h180, 16'h0000, 0);
        adc(12'h800, lin(2048, 512, 3584), 128);
        adc(12'hE01, 16'hFFFF, 0);
        $display("analog test done");
        sel = SCI_SEL_PWM;
        host_en = 1'b1;
        pin(2'h0, 16'h0064, 16'h0005, 16'h0000, 0);
        pin(2'h0, 16'h0064, 16'h0032, lin(32767, 8192, 65535), 1024);
        pin(2'h0, 16'h0064, 16'h005A, lin(58981, 8192, 65535), 1024);
        $display("pwm test done");
        sel = SCI_SEL_FREQ;
        pin(2'h0, 16'h000A, 16'h0005, 16'hFFFF, 0);
        pin(2'h0, 16'h001E, 16'h000F, 16'h8000, 10923);
        pin(2'h1, 16'h001E, 16'h000F, 16'hFFFF, 0);
        host_en = 1'b0;
        pin(2'h0, 16'h001E, 16'h000F, 16'h0000, 0);
        chk("pin_stop", 16'h0001, {15'h0, motor_stop}, 0);
        $display("freq test done");
        summarize();
    end
endmodule
`default_nettype wire
